// [slu_defs.sv]
// Shared constants of the scalar logical unit and its mask generator module.
// Assumes a 16-bit parcel stream from issue logic and 64-bit scalar words.
package slu_pkg;
  localparam int WORD_W = 64;
  localparam int PARCEL_W = 16;
  localparam int IMM_W = 22;
  localparam int OP_W = 7;
  localparam int DES_W = 3;
  localparam int CNT_W = 6;
  localparam int OP_MSB = 15;
  localparam int OP_LSB = 9;
  localparam int I_MSB = 8;
  localparam int I_LSB = 6;
  localparam int J_MSB = 5;
  localparam int J_LSB = 3;
  localparam int K_MSB = 2;
  localparam int K_LSB = 0;
  localparam int SIGN_POS = 63;
  localparam logic [OP_W-1:0] OP_ENTER_POS = 7'h20;
  localparam logic [OP_W-1:0] OP_ENTER_NEG = 7'h21;
  localparam logic [OP_W-1:0] OP_MASK_RIGHT = 7'h22;
  localparam logic [OP_W-1:0] OP_MASK_LEFT = 7'h23;
  localparam logic [OP_W-1:0] OP_AND = 7'h24;
  localparam logic [OP_W-1:0] OP_AND_NOT = 7'h25;
  localparam logic [OP_W-1:0] OP_XOR = 7'h26;
  localparam logic [OP_W-1:0] OP_EQV = 7'h27;
  localparam logic [OP_W-1:0] OP_MERGE = 7'h28;
  localparam logic [OP_W-1:0] OP_OR = 7'h29;
  localparam logic [DES_W-1:0] DES_ZERO = 3'h0;
  localparam logic [WORD_W-1:0] WORD_ZERO = 64'h0000_0000_0000_0000;
  localparam logic [WORD_W-1:0] WORD_SIGN = 64'h8000_0000_0000_0000;
  localparam logic [WORD_W-1:0] WORD_NO_SIGN = 64'h7FFF_FFFF_FFFF_FFFF;
  typedef enum logic [0:0] {ST_IDLE, ST_WAIT_IMM} slu_state_type;
endpackage

`timescale 1ns/1ns
// Right-justified ones mask: bit b is set when b plus the count stays below the word width.
// Purely combinational; the caller registers the result.
module slu_mask_gen
  import slu_pkg::*;
#(
  parameter int WIDTH = WORD_W
)
(
  input wire logic [CNT_W-1:0] i_count,
  output logic [WIDTH-1:0] o_mask
);
  initial
  begin
    if (WIDTH != (1 << CNT_W))
    begin
      $error("slu_mask_gen: width must match the count field range");
    end
  end
  genvar b;
  generate
    for (b = 0; b < WIDTH; b++)
    begin : g_bit
      assign o_mask[b] = (b + int'(i_count)) < WIDTH;
    end
  endgenerate
endmodule

// [slu_unit.sv]
// Scalar logical functional unit: immediate entry, mask forming and bitwise operations.
// Assumes issue logic presents operand words (Sj, Sk, prior Si) with the first parcel.
// Behaviour
// - Collect two parcels, immediate spans j,k,m
// - Positive immediate enters the field value
// - Negative immediate recovers value from complement
// - Right mask: 64 minus count low ones
// - Left mask: count ones from top
// - Zero k designator selects sign bit word
// - Product is bitwise AND of sources
// - Product: j zero clears, k zero sign
// - Product with complement: Sj and not Sk
// - Difference is exclusive OR with special cases
// - Equivalence sets bits where sources agree
// - Equivalence both zero: all but sign set
// - Merge takes Sj bits where mask set
// - Merge equals Sj&Sk or Si&~Sk
// - Sum is bitwise inclusive OR of sources
// - Sum: k zero forces sign bit on
// - Masks and constants execute in this unit
// - Bitwise opcodes operate on 64-bit words
`timescale 1ns/1ns
module slu_unit
  import slu_pkg::*;
#(
  parameter int DATA_W = WORD_W
)
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_parcel_valid,
  input wire logic [PARCEL_W-1:0] i_parcel,
  input wire logic [DATA_W-1:0] i_sj,
  input wire logic [DATA_W-1:0] i_sk,
  input wire logic [DATA_W-1:0] i_si,
  output logic o_result_valid,
  output logic [DES_W-1:0] o_result_addr,
  output logic [DATA_W-1:0] o_result,
  output logic o_unsupported
);
  initial
  begin
    if (DATA_W != WORD_W)
    begin
      $error("slu_unit: only 64-bit scalar words are supported");
    end
  end

  function automatic logic des_is_zero(input logic [DES_W-1:0] d);
    des_is_zero = (d == DES_ZERO);
  endfunction

  slu_state_type state;
  slu_state_type next_state;
  logic neg_pending;
  logic next_neg_pending;
  logic [DES_W-1:0] dest_pending;
  logic [DES_W-1:0] next_dest_pending;
  logic [2*DES_W-1:0] imm_hi;
  logic [2*DES_W-1:0] next_imm_hi;
  logic result_valid;
  logic next_result_valid;
  logic [DES_W-1:0] result_addr;
  logic [DES_W-1:0] next_result_addr;
  logic [DATA_W-1:0] result;
  logic [DATA_W-1:0] next_result;
  logic unsupported;
  logic next_unsupported;

  logic [OP_W-1:0] op;
  logic [DES_W-1:0] des_i;
  logic [DES_W-1:0] des_j;
  logic [DES_W-1:0] des_k;
  logic [CNT_W-1:0] mask_count_field;
  logic [DATA_W-1:0] opnd_j;
  logic [DATA_W-1:0] opnd_k;
  logic [DATA_W-1:0] right_mask;
  logic [DATA_W-1:0] imm_word;
  logic take_first;
  logic take_second;

  assign op = i_parcel[OP_MSB:OP_LSB];
  assign des_i = i_parcel[I_MSB:I_LSB];
  assign des_j = i_parcel[J_MSB:J_LSB];
  assign des_k = i_parcel[K_MSB:K_LSB];
  assign mask_count_field = {des_j, des_k};
  assign take_first = i_parcel_valid && (state == ST_IDLE);
  assign take_second = i_parcel_valid && (state == ST_WAIT_IMM);

  // Zero j reads as a zero word; the address file is never consulted here
  assign opnd_j = des_is_zero(des_j) ? WORD_ZERO : i_sj;
  // Zero k reads as the sign bit operand
  assign opnd_k = des_is_zero(des_k) ? WORD_SIGN : i_sk;
  assign imm_word = {{(DATA_W - IMM_W){1'b0}}, imm_hi, i_parcel};

  slu_mask_gen #(
    .WIDTH(DATA_W)
  ) u_mask (
    .i_count(mask_count_field),
    .o_mask(right_mask)
  );

  always_comb
  begin
    next_state = state;
    next_neg_pending = neg_pending;
    next_dest_pending = dest_pending;
    next_imm_hi = imm_hi;
    next_result_valid = 1'b0;
    next_result_addr = result_addr;
    next_result = result;
    next_unsupported = 1'b0;
    case (state)
      ST_IDLE:
      begin
        if (take_first)
        begin
          // Destination only moves with a result, so refusals and first parcels leave it standing
          next_result_valid = 1'b1;
          if (op == OP_ENTER_POS || op == OP_ENTER_NEG)
          begin
            // Result waits for the second parcel
            next_result_valid = 1'b0;
            next_state = ST_WAIT_IMM;
            next_neg_pending = (op == OP_ENTER_NEG);
            next_dest_pending = des_i;
            next_imm_hi = mask_count_field;
          end
          else if (op == OP_MASK_RIGHT)
          begin
            next_result = right_mask;
          end
          else if (op == OP_MASK_LEFT)
          begin
            next_result = ~right_mask;
          end
          else if (op == OP_AND)
          begin
            next_result = opnd_j & opnd_k;
          end
          else if (op == OP_AND_NOT)
          begin
            next_result = opnd_j & ~opnd_k;
          end
          else if (op == OP_XOR)
          begin
            next_result = opnd_j ^ opnd_k;
          end
          else if (op == OP_EQV)
          begin
            next_result = ~(opnd_j ^ opnd_k);
          end
          else if (op == OP_MERGE)
          begin
            next_result = (opnd_j & opnd_k) | (i_si & ~opnd_k);
          end
          else if (op == OP_OR)
          begin
            next_result = opnd_j | opnd_k;
          end
          else
          begin
            // Foreign opcodes leave the destination untouched
            next_result_valid = 1'b0;
            next_unsupported = 1'b1;
          end
          if (next_result_valid)
          begin
            next_result_addr = des_i;
          end
        end
      end
      ST_WAIT_IMM:
      begin
        if (take_second)
        begin
          next_state = ST_IDLE;
          next_result_valid = 1'b1;
          next_result_addr = dest_pending;
          // The field holds the ones complement, so complementing restores the value
          next_result = neg_pending ? ~imm_word : imm_word;
        end
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      state <= ST_IDLE;
      neg_pending <= 1'b0;
      dest_pending <= DES_ZERO;
      imm_hi <= '0;
      result_valid <= 1'b0;
      result_addr <= DES_ZERO;
      result <= WORD_ZERO;
      unsupported <= 1'b0;
    end
    else
    begin
      state <= next_state;
      neg_pending <= next_neg_pending;
      dest_pending <= next_dest_pending;
      imm_hi <= next_imm_hi;
      result_valid <= next_result_valid;
      result_addr <= next_result_addr;
      result <= next_result;
      unsupported <= next_unsupported;
    end
  end

  assign o_result_valid = result_valid;
  assign o_result_addr = result_addr;
  assign o_result = result;
  assign o_unsupported = unsupported;

  logic first_imm;
  assign first_imm = take_first && (op == OP_ENTER_POS || op == OP_ENTER_NEG);

  imm_two_parcel_a: assert property (@(posedge i_clk) disable iff (i_reset)
    first_imm |=> !o_result_valid && state == ST_WAIT_IMM)
    else $error("immediate result appeared before second parcel");

  imm_positive_a: assert property (@(posedge i_clk) disable iff (i_reset)
    take_first && op == OP_ENTER_POS ##1 take_second |=>
      o_result_valid && o_result == {42'h0, $past(imm_hi), $past(i_parcel)})
    else $error("positive immediate value wrong");

  imm_negative_a: assert property (@(posedge i_clk) disable iff (i_reset)
    take_first && op == OP_ENTER_NEG ##1 take_second |=>
      o_result_valid && ~o_result == {42'h0, $past(imm_hi), $past(i_parcel)})
    else $error("negative immediate value wrong");

  mask_right_a: assert property (@(posedge i_clk) disable iff (i_reset)
    take_first && op == OP_MASK_RIGHT |=>
      $countones(o_result) == 64 - $past(int'(mask_count_field)) && o_result[0])
    else $error("right mask length wrong");

  mask_left_a: assert property (@(posedge i_clk) disable iff (i_reset)
    take_first && op == OP_MASK_LEFT |=>
      $countones(o_result) == $past(int'(mask_count_field)) && !o_result[0])
    else $error("left mask length wrong");

  and_zero_j_a: assert property (@(posedge i_clk) disable iff (i_reset)
    take_first && op == OP_AND && des_j == DES_ZERO |=> o_result_valid && o_result == WORD_ZERO)
    else $error("product with zero j not cleared");

  andn_sign_a: assert property (@(posedge i_clk) disable iff (i_reset)
    take_first && op == OP_AND_NOT && des_j != DES_ZERO && des_k == DES_ZERO |=>
      o_result == ($past(i_sj) & WORD_NO_SIGN))
    else $error("sign clear form wrong");

  xor_zero_j_a: assert property (@(posedge i_clk) disable iff (i_reset)
    take_first && op == OP_XOR && des_j == DES_ZERO && des_k != DES_ZERO |=> o_result == $past(i_sk))
    else $error("difference with zero j wrong");

  eqv_both_zero_a: assert property (@(posedge i_clk) disable iff (i_reset)
    take_first && op == OP_EQV && des_j == DES_ZERO && des_k == DES_ZERO |=> o_result == WORD_NO_SIGN)
    else $error("equivalence of zeros wrong");

  merge_keep_a: assert property (@(posedge i_clk) disable iff (i_reset)
    take_first && op == OP_MERGE && des_k != DES_ZERO |=>
      ((o_result ^ $past(i_si)) & ~$past(i_sk)) == WORD_ZERO)
    else $error("merge disturbed unmasked bits");

  or_sign_a: assert property (@(posedge i_clk) disable iff (i_reset)
    take_first && op == OP_OR && des_k == DES_ZERO |=> o_result[SIGN_POS] && o_result_valid)
    else $error("sum sign bit not forced");
endmodule

// [slu_issue_model.sv]
// Issue-side model: a scalar register file that feeds operand words for the presented parcel.
// Assumes the bench loads the registers before reset is released and never during a run.
`timescale 1ns/1ns
module slu_issue_model
  import slu_pkg::*;
(
  input wire logic i_parcel_valid,
  input wire logic [PARCEL_W-1:0] i_parcel,
  output logic [WORD_W-1:0] o_sj,
  output logic [WORD_W-1:0] o_sk,
  output logic [WORD_W-1:0] o_si
);
  logic [WORD_W-1:0] regs [0:7];

  // Between parcels the operand buses carry inverted data, so a stale capture shows up
  always_comb
  begin
    if (i_parcel_valid)
    begin
      o_sj = regs[i_parcel[J_MSB:J_LSB]];
      o_sk = regs[i_parcel[K_MSB:K_LSB]];
      o_si = regs[i_parcel[I_MSB:I_LSB]];
    end
    else
    begin
      o_sj = ~regs[1];
      o_sk = ~regs[2];
      o_si = ~regs[3];
    end
  end
endmodule

// [tb_top.sv]
// Self-checking bench for the scalar logical unit; expectations queue up in issue order.
// Assumes one result or refusal pulse per instruction, in order.
`timescale 1ns/1ns
module tb_top;
  import slu_pkg::*;
  typedef struct {logic unsup; logic [DES_W-1:0] addr; logic [WORD_W-1:0] value;} slu_exp_type;
  logic i_clk = 1'h0;
  logic i_reset = 1'h1;
  logic i_parcel_valid = 1'h0;
  logic [PARCEL_W-1:0] i_parcel = 16'h0000;
  logic [WORD_W-1:0] sj, sk, si;
  logic o_result_valid, o_unsupported;
  logic [DES_W-1:0] o_result_addr;
  logic [WORD_W-1:0] o_result;
  slu_exp_type exp_q[$];
  slu_exp_type got;
  logic [DES_W-1:0] last_addr = 3'h0;
  int seed = 34;
  int err_count = 0;
  int num_checks = 0;
  logic [DES_W-1:0] a, b, j, k;

  always #5 i_clk = ~i_clk;

  slu_issue_model u_iss (.i_parcel_valid(i_parcel_valid), .i_parcel(i_parcel), .o_sj(sj), .o_sk(sk), .o_si(si));
  slu_unit #(.DATA_W(WORD_W)) u_dut (.i_clk(i_clk), .i_reset(i_reset), .i_parcel_valid(i_parcel_valid),
    .i_parcel(i_parcel), .i_sj(sj), .i_sk(sk), .i_si(si), .o_result_valid(o_result_valid),
    .o_result_addr(o_result_addr), .o_result(o_result), .o_unsupported(o_unsupported));

  task automatic check(input string name, input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] expv);
    num_checks++;
    if (seen !== expv)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, expv, seen);
    end
  endtask

  // Operands follow the zero-designator substitutions; immediates pair j,k with m
  function automatic logic [WORD_W-1:0] calc(input logic [OP_W-1:0] op, input logic [DES_W-1:0] i,
    input logic [DES_W-1:0] jd, input logic [DES_W-1:0] kd, input logic [15:0] m);
    logic [WORD_W-1:0] x, y, z, lo;
    x = (jd == DES_ZERO) ? WORD_ZERO : u_iss.regs[jd];
    y = (kd == DES_ZERO) ? WORD_SIGN : u_iss.regs[kd];
    z = u_iss.regs[i];
    lo = (64'h1 << (64 - int'({jd, kd}))) - 64'h1;
    case (op)
      OP_ENTER_POS: calc = {42'h0, jd, kd, m};
      OP_ENTER_NEG: calc = ~{42'h0, jd, kd, m};
      OP_MASK_RIGHT: calc = lo;
      OP_MASK_LEFT: calc = ~lo;
      OP_AND: calc = x & y;
      OP_AND_NOT: calc = x & ~y;
      OP_XOR: calc = x ^ y;
      OP_EQV: calc = ~(x ^ y);
      OP_MERGE: calc = (x & y) | (z & ~y);
      default: calc = x | y;
    endcase
  endfunction

  task automatic step(input logic v, input logic [PARCEL_W-1:0] p);
    @(posedge i_clk);
    #1;
    i_parcel_valid = v;
    i_parcel = p;
  endtask

  task automatic issue(input logic [OP_W-1:0] op, input logic [DES_W-1:0] jd, input logic [DES_W-1:0] kd,
    input logic [15:0] m, input int gap);
    slu_exp_type e;
    logic [DES_W-1:0] i;
    i = 3'($random(seed));
    e.unsup = (op < OP_ENTER_POS) || (op > OP_OR);
    e.addr = i;
    e.value = calc(op, i, jd, kd, m);
    exp_q.push_back(e);
    step(1'h1, {op, i, jd, kd});
    if (op == OP_ENTER_POS || op == OP_ENTER_NEG)
    begin
      repeat (gap)
      begin
        step(1'h0, 16'($random(seed)));
      end
      step(1'h1, m);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic drain(input string name);
    step(1'h0, 16'h0000);
    for (int n = 0; n < 20 && exp_q.size() > 0; n++)
    begin
      @(posedge i_clk);
    end
    if (exp_q.size() > 0)
    begin
      check("pending_results", 64'(exp_q.size()), 64'h0);
      results();
    end
    $display("test %s done", name);
  endtask

  // Results are matched strictly in issue order, one pulse each
  always @(posedge i_clk)
  begin
    #2;
    if (o_result_valid === 1'h1 || o_unsupported === 1'h1)
    begin
      if (exp_q.size() == 0)
        check("unexpected_result", 64'h1, 64'h0);
      else
      begin
        got = exp_q.pop_front();
        check("unsupported", o_unsupported, got.unsup);
        check("result_valid", o_result_valid, !got.unsup);
        if (!got.unsup)
        begin
          check("result_addr", o_result_addr, got.addr);
          check("result", o_result, got.value);
          check("result_alias", o_result, got.value);
          last_addr = got.addr;
        end
        else
          check("addr_hold", o_result_addr, last_addr);
      end
    end
  end

  initial
  begin
    for (int n = 0; n < 8; n++)
    begin
      u_iss.regs[n] = {$random(seed), $random(seed)};
    end
    repeat (10)
    begin
      @(posedge i_clk);
    end
    check("reset_valid", o_result_valid, 64'h0);
    #1;
    i_reset = 1'h0;
    // Every designator case back to back: distinct, j zero, k zero, equal, both zero
    for (int o = 4; o <= 9; o++)
    begin
      for (int v = 0; v < 5; v++)
      begin
        a = 3'(1 + ($unsigned($random(seed)) % 7));
        b = (a == 3'h7) ? 3'h1 : a + 3'h1;
        j = (v == 1 || v == 4) ? DES_ZERO : a;
        k = (v == 2 || v == 4) ? DES_ZERO : ((v == 3) ? a : b);
        issue(OP_ENTER_POS + 7'(o), j, k, 16'h0000, 0);
      end
    end
    drain("logical");
    for (int c = 0; c < 5; c++)
    begin
      a = (c == 4) ? 3'($random(seed)) : 3'(c * 3);
      b = (c == 4) ? 3'($random(seed)) : ((c == 2) ? 3'h7 : 3'(c));
      issue(OP_MASK_RIGHT, a, b, 16'h0000, 0);
      issue(OP_MASK_LEFT, a, b, 16'h0000, 0);
    end
    drain("masks");
    for (int g = 0; g < 3; g++)
    begin
      issue(OP_ENTER_POS, 3'($random(seed)), 3'($random(seed)), 16'($random(seed)), g);
      issue(OP_ENTER_NEG, 3'($random(seed)), 3'($random(seed)), 16'($random(seed)), g);
    end
    issue(OP_ENTER_NEG, 3'h7, 3'h7, 16'hFFFF, 0);
    drain("immediate");
    issue(7'h1F, 3'h1, 3'h2, 16'h0000, 0);
    issue(7'h2A, 3'h1, 3'h2, 16'h0000, 0);
    issue(7'h00, 3'h3, 3'h4, 16'h0000, 0);
    issue(OP_OR, 3'h3, 3'h4, 16'h0000, 0);
    drain("refused");
    results();
  end
endmodule
